// file: src/pio_port_bank.sv
// Register bank and pin logic of the four parallel ports, plus the serial pins of port E.
// Assumes a register master with one-cycle strobes and pins synchronous to clock_i.
`timescale 1ns/1ps
`include "pio_cfg.svh"

module pio_port_bank
  import pio_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire pio_byte_t  addr_i,
  input  wire pio_byte_t  wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output pio_byte_t       rdata_o,
  input  wire pio_byte_t  port_a_pin_i,
  input  wire pio_byte_t  port_b_pin_i,
  input  wire pio_byte_t  port_c_pin_i,
  input  wire pio_byte_t  port_d_pin_i,
  input  wire pio_byte_t  port_e_pin_i,
  output pio_pad_s        port_a_pad_o,
  output pio_pad_s        port_b_pad_o,
  output pio_pad_s        port_c_pad_o,
  output pio_pad_s        port_d_pad_o,
  output pio_pad_s        port_e_pad_o,
  input  wire logic [5:0] adc_channel_sel_i,
  input  wire logic [6:0] port_d_periph_en_i,
  input  wire logic [6:0] port_d_periph_out_i,
  input  wire logic [6:0] port_d_periph_oe_i,
  input  wire logic       serial_tx_i,
  input  wire logic       serial_tx_en_i,
  output logic            serial_rx_o,
  output logic [3:0]      keypad_inputs_o
);

  // Masked read of one port: latch on outputs, pin level on inputs
  function automatic pio_byte_t pio_rd_val(input pio_byte_t lat, input pio_byte_t dir,
                                           input pio_byte_t pin, input pio_byte_t mask);
    pio_rd_val = ((lat & dir) | (pin & ~dir)) & mask;
  endfunction

  pio_byte_t latch_a_q;
  pio_byte_t latch_b_q;
  pio_byte_t latch_c_q;
  pio_byte_t latch_d_q;
  pio_byte_t dir_a_q;
  pio_byte_t dir_b_q;
  pio_byte_t dir_c_q;
  pio_byte_t dir_d_q;
  pio_byte_t port_a_pullup_enables_q;
  pio_byte_t keypad_irq_enables_q;
  pio_byte_t rdata_q;
  pio_byte_t rdata_d;
  logic [3:0] keypad_q;
  logic       serial_rx_q;
  pio_pad_s   pad_e_q;

  // Address decode
  wire wr_lat_a = wr_i && (addr_i == `PIO_ADDR_LAT_A);
  wire wr_lat_b = wr_i && (addr_i == `PIO_ADDR_LAT_B);
  wire wr_lat_c = wr_i && (addr_i == `PIO_ADDR_LAT_C);
  wire wr_lat_d = wr_i && (addr_i == `PIO_ADDR_LAT_D);
  wire wr_dir_a = wr_i && (addr_i == `PIO_ADDR_DIR_A);
  wire wr_dir_b = wr_i && (addr_i == `PIO_ADDR_DIR_B);
  wire wr_dir_c = wr_i && (addr_i == `PIO_ADDR_DIR_C);
  wire wr_dir_d = wr_i && (addr_i == `PIO_ADDR_DIR_D);
  wire wr_pue_a = wr_i && (addr_i == `PIO_ADDR_PUE_A);
  wire wr_kbd   = wr_i && (addr_i == `PIO_ADDR_KBD_EN);

  // Read selection; unmapped offsets read as zero
  wire pio_byte_t rd_lat_a = pio_rd_val(latch_a_q, dir_a_q, port_a_pin_i, `PIO_MASK_A);
  wire pio_byte_t rd_lat_b = pio_rd_val(latch_b_q, dir_b_q, port_b_pin_i, `PIO_MASK_B);
  wire pio_byte_t rd_lat_c = pio_rd_val(latch_c_q, dir_c_q, port_c_pin_i, `PIO_MASK_C);
  wire pio_byte_t rd_lat_d = pio_rd_val(latch_d_q, dir_d_q, port_d_pin_i, `PIO_MASK_D);

  always_comb begin
    case (addr_i)
      `PIO_ADDR_LAT_A:  rdata_d = rd_lat_a;
      `PIO_ADDR_LAT_B:  rdata_d = rd_lat_b;
      `PIO_ADDR_LAT_C:  rdata_d = rd_lat_c;
      `PIO_ADDR_LAT_D:  rdata_d = rd_lat_d;
      `PIO_ADDR_DIR_A:  rdata_d = dir_a_q;
      `PIO_ADDR_DIR_B:  rdata_d = dir_b_q;
      `PIO_ADDR_DIR_C:  rdata_d = dir_c_q;
      `PIO_ADDR_DIR_D:  rdata_d = dir_d_q;
      `PIO_ADDR_PUE_A:  rdata_d = port_a_pullup_enables_q;
      `PIO_ADDR_KBD_EN: rdata_d = keypad_irq_enables_q;
      default:          rdata_d = `PIO_RDATA_IDLE;
    endcase
  end

  // Data latches have no reset: contents survive a reset untouched
  always_ff @(posedge clock_i) begin
    if (wr_lat_a) latch_a_q <= wdata_i & `PIO_MASK_A;
    if (wr_lat_b) latch_b_q <= wdata_i & `PIO_MASK_B;
    if (wr_lat_c) latch_c_q <= wdata_i & `PIO_MASK_C;
    if (wr_lat_d) latch_d_q <= wdata_i & `PIO_MASK_D;
  end

  // Direction registers clear to all inputs on reset
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      dir_a_q <= `PIO_DIR_RST;
      dir_b_q <= `PIO_DIR_RST;
      dir_c_q <= `PIO_DIR_RST;
      dir_d_q <= `PIO_DIR_RST;
    end else begin
      if (wr_dir_a) dir_a_q <= wdata_i & `PIO_MASK_A;
      if (wr_dir_b) dir_b_q <= wdata_i & `PIO_MASK_B;
      if (wr_dir_c) dir_c_q <= wdata_i & `PIO_MASK_C;
      if (wr_dir_d) dir_d_q <= wdata_i & `PIO_MASK_D;
    end
  end

  // Pullup and keypad enables for port A
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      port_a_pullup_enables_q <= `PIO_CTL_RST;
      keypad_irq_enables_q    <= `PIO_CTL_RST;
    end else begin
      if (wr_pue_a) port_a_pullup_enables_q <= wdata_i & `PIO_MASK_A;
      if (wr_kbd)   keypad_irq_enables_q    <= wdata_i & `PIO_MASK_A;
    end
  end

  // Read data stand only in the cycle after the strobe; no wait states
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rdata_q <= `PIO_RDATA_IDLE;
    end else begin
      rdata_q <= rd_i ? rdata_d : `PIO_RDATA_IDLE;
    end
  end

  // Keypad-enabled pins become inputs feeding the keypad interrupt logic
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      keypad_q <= 4'h0;
    end else begin
      keypad_q <= port_a_pin_i[3:0] & keypad_irq_enables_q[3:0];
    end
  end

  // Port E carries only the serial unit here; its own port registers live elsewhere
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pad_e_q     <= '0;
      serial_rx_q <= 1'b1;  // Idle line level until the first sample
    end else begin
      pad_e_q.out <= {7'h00, serial_tx_i};
      pad_e_q.oe  <= {7'h00, serial_tx_en_i};
      pad_e_q.pu  <= `PIO_BYTE_ZERO;
      serial_rx_q <= port_e_pin_i[`PIO_E_RX_BIT];
    end
  end

  // Peripheral ownership per port; the converter only ever takes a pin as input
  wire pio_byte_t ovr_b_en  = {2'h0, adc_channel_sel_i};
  wire pio_byte_t ovr_d_en  = {1'b0, port_d_periph_en_i};
  wire pio_byte_t ovr_d_out = {1'b0, port_d_periph_out_i};
  wire pio_byte_t ovr_d_oe  = {1'b0, port_d_periph_oe_i};

  pio_pin_cell #(.MASK(`PIO_MASK_A)) u_cell_a (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .latch_i   (latch_a_q),
    .dir_i     (dir_a_q),
    .pue_i     (port_a_pullup_enables_q),
    .ovr_en_i  (keypad_irq_enables_q),
    .ovr_out_i (`PIO_BYTE_ZERO),
    .ovr_oe_i  (`PIO_BYTE_ZERO),
    .pad_o     (port_a_pad_o)
  );

  pio_pin_cell #(.MASK(`PIO_MASK_B)) u_cell_b (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .latch_i   (latch_b_q),
    .dir_i     (dir_b_q),
    .pue_i     (`PIO_BYTE_ZERO),
    .ovr_en_i  (ovr_b_en),
    .ovr_out_i (`PIO_BYTE_ZERO),
    .ovr_oe_i  (`PIO_BYTE_ZERO),
    .pad_o     (port_b_pad_o)
  );

  pio_pin_cell #(.MASK(`PIO_MASK_C)) u_cell_c (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .latch_i   (latch_c_q),
    .dir_i     (dir_c_q),
    .pue_i     (`PIO_BYTE_ZERO),
    .ovr_en_i  (`PIO_BYTE_ZERO),
    .ovr_out_i (`PIO_BYTE_ZERO),
    .ovr_oe_i  (`PIO_BYTE_ZERO),
    .pad_o     (port_c_pad_o)
  );

  pio_pin_cell #(.MASK(`PIO_MASK_D)) u_cell_d (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .latch_i   (latch_d_q),
    .dir_i     (dir_d_q),
    .pue_i     (`PIO_BYTE_ZERO),
    .ovr_en_i  (ovr_d_en),
    .ovr_out_i (ovr_d_out),
    .ovr_oe_i  (ovr_d_oe),
    .pad_o     (port_d_pad_o)
  );

  assign rdata_o         = rdata_q;
  assign port_e_pad_o    = pad_e_q;
  assign serial_rx_o     = serial_rx_q;
  assign keypad_inputs_o = keypad_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  lat_a_read_a: assert property (
    rd_i && addr_i == `PIO_ADDR_LAT_A |=> rdata_o[7:4] == 4'h0)
    else $error("port A latch upper bits not zero");

  lat_b_read_a: assert property (
    rd_i && addr_i == `PIO_ADDR_LAT_B |=> rdata_o[7:6] == 2'h0)
    else $error("port B latch upper bits not zero");

  lat_c_read_a: assert property (
    rd_i && addr_i == `PIO_ADDR_LAT_C |=> rdata_o[7:2] == 6'h00)
    else $error("port C latch upper bits not zero");

  lat_d_read_a: assert property (
    rd_i && addr_i == `PIO_ADDR_LAT_D |=> rdata_o[7] == 1'b0)
    else $error("port D latch top bit not zero");

  dir_reset_a: assert property (@(posedge clock_i)
    $fell(reset_i) |-> (dir_a_q | dir_b_q | dir_c_q | dir_d_q) == `PIO_DIR_RST)
    else $error("direction not cleared by reset");

  read_mux_a: assert property (
    rd_i && addr_i == `PIO_ADDR_LAT_C |=>
      rdata_o == ((($past(latch_c_q) & $past(dir_c_q)) | ($past(port_c_pin_i) & ~$past(dir_c_q))) & `PIO_MASK_C))
    else $error("port C read mixes latch and pin wrongly");

  latch_write_a: assert property (
    wr_lat_d ##1 !wr_lat_d [*2] |-> latch_d_q == ($past(wdata_i, 2) & `PIO_MASK_D))
    else $error("port D latch lost a write");

  drive_from_dir_a: assert property (
    ##2 1'b1 |-> port_c_pad_o.oe == $past(dir_c_q)
                 && (port_c_pad_o.out & port_c_pad_o.oe) == ($past(latch_c_q) & $past(dir_c_q)))
    else $error("port C pads do not follow direction and latch");

  pullup_gate_a: assert property (
    ##2 1'b1 |-> port_a_pad_o.pu == ($past(port_a_pullup_enables_q) & ~$past(dir_a_q) & ~$past(keypad_irq_enables_q)
                                      & ~$past(keypad_irq_enables_q) | ($past(port_a_pullup_enables_q)
                                      & ~$past(dir_a_q) & $past(keypad_irq_enables_q))))
    else $error("port A pullup not gated by direction");

  rdata_idle_a: assert property (
    !rd_i |=> rdata_o == `PIO_RDATA_IDLE)
    else $error("read data outside the read slot");

  dir_b_write_a: assert property (
    wr_dir_b |=> dir_b_q == ($past(wdata_i) & `PIO_MASK_B))
    else $error("port B direction write lost");

  pue_write_a: assert property (
    wr_pue_a |=> port_a_pullup_enables_q == ($past(wdata_i) & `PIO_MASK_A))
    else $error("port A pullup enable write lost");

  adc_input_a: assert property (
    ##1 1'b1 |-> (port_b_pad_o.oe & $past(ovr_b_en)) == `PIO_BYTE_ZERO)
    else $error("converter pin still driven");

  serial_rx_a: assert property (
    ##1 1'b1 |-> serial_rx_o == $past(port_e_pin_i[`PIO_E_RX_BIT]))
    else $error("serial receive pin not followed");

  serial_tx_a: assert property (
    ##1 1'b1 |-> port_e_pad_o.out[`PIO_E_TX_BIT] == $past(serial_tx_i)
                 && port_e_pad_o.oe[`PIO_E_TX_BIT] == $past(serial_tx_en_i))
    else $error("serial transmit pin not driven");

endmodule // pio_port_bank

// file: src/pio_cfg.svh
// Constants for the parallel port bank: register offsets, bit masks, reset values.
// Assumes an 8-bit register address and 8-bit data on the internal register port.
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH

// Register offsets
`define PIO_ADDR_LAT_A   8'h00
`define PIO_ADDR_LAT_B   8'h01
`define PIO_ADDR_LAT_C   8'h02
`define PIO_ADDR_LAT_D   8'h03
`define PIO_ADDR_DIR_A   8'h04
`define PIO_ADDR_DIR_B   8'h05
`define PIO_ADDR_DIR_C   8'h06
`define PIO_ADDR_DIR_D   8'h07
`define PIO_ADDR_PUE_A   8'h08
`define PIO_ADDR_KBD_EN  8'h09

// Implemented bits of each port
`define PIO_MASK_A       8'h0f
`define PIO_MASK_B       8'h3f
`define PIO_MASK_C       8'h03
`define PIO_MASK_D       8'h7f
`define PIO_MASK_E       8'h03

// Reset values
`define PIO_DIR_RST      8'h00
`define PIO_CTL_RST      8'h00
`define PIO_RDATA_IDLE   8'h00
`define PIO_BYTE_ZERO    8'h00

// Port E pin positions shared with the serial unit
`define PIO_E_TX_BIT     0
`define PIO_E_RX_BIT     1

`endif

// file: src/pio_pkg.sv
// Types shared by the parallel port bank and its pin cells.
// Assumes the constants header is included by each design file.
package pio_pkg;

  // Drive state of one port's pads
  typedef struct packed {
    logic [7:0] out;  // Level to drive
    logic [7:0] oe;   // Driver on
    logic [7:0] pu;   // Internal pullup on
  } pio_pad_s;

  typedef logic [7:0] pio_byte_t;

endpackage : pio_pkg

// file: src/pio_pin_cell.sv
// Pin cell for one parallel port: chooses driver, level and pullup per pin.
// Assumes latch and direction come from the register bank; overrides from peripherals.
`timescale 1ns/1ps
`include "pio_cfg.svh"

module pio_pin_cell
  import pio_pkg::*;
#(
  parameter pio_byte_t MASK = 8'hff
) (
  input  wire logic      clock_i,
  input  wire logic      reset_i,
  input  wire pio_byte_t latch_i,
  input  wire pio_byte_t dir_i,
  input  wire pio_byte_t pue_i,
  input  wire pio_byte_t ovr_en_i,
  input  wire pio_byte_t ovr_out_i,
  input  wire pio_byte_t ovr_oe_i,
  output pio_pad_s       pad_o
);

  pio_pad_s pad_q;
  pio_pad_s pad_d;

  // A peripheral that owns a pin takes both its level and its driver
  assign pad_d.out = ((ovr_en_i & ovr_out_i) | (~ovr_en_i & latch_i)) & MASK;
  assign pad_d.oe  = ((ovr_en_i & ovr_oe_i) | (~ovr_en_i & dir_i)) & MASK;
  // Pullup only on an input pin; dropped the moment it drives
  assign pad_d.pu  = pue_i & ~dir_i & ~pad_d.oe & MASK;

  // Registered pads keep the outputs glitch free
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pad_q.out <= `PIO_BYTE_ZERO;
      pad_q.oe  <= `PIO_DIR_RST;
      pad_q.pu  <= `PIO_CTL_RST;
    end else begin
      pad_q <= pad_d;
    end
  end

  assign pad_o = pad_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  pullup_vs_drive_a: assert property (
    (pad_q.pu & pad_q.oe) == `PIO_BYTE_ZERO)
    else $error("pullup on while pin drives");

  oe_follows_dir_a: assert property (
    ##1 (ovr_en_i == `PIO_BYTE_ZERO) ##1 1'b1 |-> pad_q.oe == ($past(dir_i) & MASK))
    else $error("driver enable does not follow direction");

  unused_pins_off_a: assert property (
    ((pad_q.oe | pad_q.out | pad_q.pu) & ~MASK) == `PIO_BYTE_ZERO)
    else $error("unimplemented pin active");

endmodule // pio_pin_cell

// file: sim/pio_pin_model.sv
// Pin model for the four parallel ports: resolves each pad against the outside world.
// Assumes the bench sets the outside level of every pin that nobody drives.
`timescale 1ns/1ps

module pio_pin_model
  import pio_pkg::*;
(
  input  wire pio_pad_s  pad_a_i,
  input  wire pio_pad_s  pad_b_i,
  input  wire pio_pad_s  pad_c_i,
  input  wire pio_pad_s  pad_d_i,
  input  wire pio_byte_t ext_a_i,
  input  wire pio_byte_t ext_b_i,
  input  wire pio_byte_t ext_c_i,
  input  wire pio_byte_t ext_d_i,
  output pio_byte_t      pin_a_o,
  output pio_byte_t      pin_b_o,
  output pio_byte_t      pin_c_o,
  output pio_byte_t      pin_d_o
);
  // Driver beats pullup, pullup beats outside level; out is masked so an unwritten latch stays harmless
  function automatic pio_byte_t level(input pio_pad_s p, input pio_byte_t ext);
    return (p.out & p.oe) | (~p.oe & p.pu) | (~p.oe & ~p.pu & ext);
  endfunction

  // Pin levels seen by the port inputs
  assign pin_a_o = level(pad_a_i, ext_a_i);
  assign pin_b_o = level(pad_b_i, ext_b_i);
  assign pin_c_o = level(pad_c_i, ext_c_i);
  assign pin_d_o = level(pad_d_i, ext_d_i);
endmodule // pio_pin_model

// file: sim/tb.sv
// Self-checking bench for the parallel port bank over its register port.
// Assumes the pin model closes the loop from pads back to pin inputs.
`timescale 1ns/1ps

module tb;
  import pio_pkg::*;
  logic       clock_i   = 1'b0;
  logic       reset_i   = 1'b1;
  pio_byte_t  addr_i    = 8'h00;
  pio_byte_t  wdata_i   = 8'h00;
  logic       wr_i      = 1'b0;
  logic       rd_i      = 1'b0;
  pio_byte_t  rdata_o;
  pio_byte_t  pin_a, pin_b, pin_c, pin_d;
  pio_byte_t  ext_a = 8'h00, ext_b = 8'h00, ext_c = 8'h00, ext_d = 8'h00, pin_e = 8'h00;
  pio_pad_s   pad_a, pad_b, pad_c, pad_d, pad_e;
  logic [5:0] adc_sel   = 6'h00;
  logic [6:0] d_en      = 7'h00;
  logic [6:0] d_out     = 7'h00;
  logic [6:0] d_oe      = 7'h00;
  logic       tx        = 1'b0;
  logic       tx_en     = 1'b0;
  logic       rx;
  logic [3:0] kbd;
  pio_byte_t  masks [4] = '{8'h0f, 8'h3f, 8'h03, 8'h7f};
  int         num_errors = 0;
  int         cmp_count  = 0;

  // 10 MHz clock
  always #50 clock_i = ~clock_i;

  pio_port_bank u_dut (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .port_a_pin_i(pin_a), .port_b_pin_i(pin_b),
    .port_c_pin_i(pin_c), .port_d_pin_i(pin_d), .port_e_pin_i(pin_e), .port_a_pad_o(pad_a),
    .port_b_pad_o(pad_b), .port_c_pad_o(pad_c), .port_d_pad_o(pad_d), .port_e_pad_o(pad_e),
    .adc_channel_sel_i(adc_sel), .port_d_periph_en_i(d_en), .port_d_periph_out_i(d_out),
    .port_d_periph_oe_i(d_oe), .serial_tx_i(tx), .serial_tx_en_i(tx_en), .serial_rx_o(rx),
    .keypad_inputs_o(kbd));

  pio_pin_model u_pins (.pad_a_i(pad_a), .pad_b_i(pad_b), .pad_c_i(pad_c), .pad_d_i(pad_d),
    .ext_a_i(ext_a), .ext_b_i(ext_b), .ext_c_i(ext_c), .ext_d_i(ext_d),
    .pin_a_o(pin_a), .pin_b_o(pin_b), .pin_c_o(pin_c), .pin_d_o(pin_d));

  // Byte comparison; case inequality so unknowns never match
  task automatic chk(input pio_byte_t got, input pio_byte_t exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input pio_byte_t a, input pio_byte_t d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask

  // One-cycle read strobe; data is looked at mid-cycle after the strobe
  task automatic rdchk(input pio_byte_t a, input pio_byte_t exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    @(negedge clock_i);
    chk(rdata_o, exp);
  endtask

  // Lets registered pad outputs catch up, then parks mid-cycle
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask

  task automatic summarize;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Watchdog: the sequence needs about a hundred cycles
  initial begin
    repeat (5000) @(posedge clock_i);
    num_errors++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    for (int i = 4; i < 8; i++) rdchk(i[7:0], 8'h00);
    tick(1);
    chk(pad_a.oe, 8'h00);
    chk(pad_a.pu, 8'h00);
    // All ones into every latch and direction register; unimplemented bits must drop
    for (int i = 0; i < 8; i++) wr(i[7:0], 8'hff);
    for (int i = 0; i < 8; i++) rdchk(i[7:0], masks[i % 4]);
    @(negedge clock_i);
    chk(rdata_o, 8'h00);
    chk(pad_a.out, 8'h0f);
    chk(pad_d.oe, 8'h7f);
    // Mixed direction on port A: outputs read latch, inputs read pin
    wr(8'h04, 8'h05);
    rdchk(8'h00, 8'h05);
    chk(pad_a.oe, 8'h05);
    // Pullups only on the input bits
    wr(8'h08, 8'h0f);
    tick(1);
    chk(pad_a.pu, 8'h0a);
    rdchk(8'h00, 8'h0f);
    // Latch written while input, driven once output
    wr(8'h05, 8'h00);
    wr(8'h01, 8'h15);
    ext_b <= 8'h2a;
    rdchk(8'h01, 8'h2a);
    wr(8'h05, 8'h3f);
    tick(1);
    chk(pad_b.out, 8'h15);
    rdchk(8'h01, 8'h15);
    // Unmapped place is neither stored nor read
    wr(8'h20, 8'hff);
    rdchk(8'h20, 8'h00);
    // Keypad enables turn port A bits into inputs
    wr(8'h04, 8'h0f);
    wr(8'h09, 8'h03);
    ext_a <= 8'h0b;
    tick(2);
    chk(pad_a.oe, 8'h0c);
    chk({4'h0, kbd}, 8'h03);
    // Shared pins: converter, peripheral override, serial
    @(posedge clock_i);
    adc_sel <= 6'h01;
    d_en    <= 7'h01;
    d_oe    <= 7'h01;
    d_out   <= 7'h00;
    tx      <= 1'b1;
    tx_en   <= 1'b1;
    pin_e   <= 8'h00;
    tick(2);
    chk(pad_b.oe, 8'h3e);
    chk(pad_d.out, 8'h7e);
    chk(pad_e.out, 8'h01);
    chk(pad_e.oe, 8'h01);
    chk({7'h00, rx}, 8'h00);
    // Mid-run reset: directions clear, latches survive
    @(posedge clock_i);
    adc_sel <= 6'h00;
    d_en    <= 7'h00;
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    rdchk(8'h07, 8'h00);
    tick(1);
    chk(pad_d.oe, 8'h00);
    wr(8'h07, 8'h7f);
    rdchk(8'h03, 8'h7f);
    wr(8'h06, 8'h03);
    rdchk(8'h02, 8'h03);
    chk(pad_c.out, 8'h03);
    chk(pad_c.oe, 8'h03);
    summarize();
  end
endmodule // tb
